// *** logic/iopm_top.sv ***
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "iopm_regs.svh"
module iopm_top
	import iopm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic RESET_PIN_DISABLE_CONFIG_I,
	input wire logic LOW_SPEED_OSC_TICK_I,
	input wire logic [31:0] PIN_I,
	output logic [31:0] PIN_O,
	output logic [31:0] PIN_OE_N_O,
	output logic [31:0] PULL_WEAK_O,
	output logic [31:0] PULL_VWEAK_O,
	output logic [31:0] SCHMITT_O,
	output logic [31:0] FAST_SLEW_O,
	output logic SHARED_PULLUP_O
);
	// ============================================================
	// Storage
	localparam logic [3:0][7:0] port_mask = {`IOPM_MASK_P3, `IOPM_MASK_P2,
		`IOPM_MASK_P1, `IOPM_MASK_P0};

	logic [3:0][7:0] latch;
	logic [3:0][7:0] mode_select_low;
	logic [3:0][7:0] mode_select_high;
	logic [3:0][7:0] input_type_select;
	logic [3:0][7:0] slew_rate_select;
	logic shared_pin_pullup_enable;
	logic [31:0] pin_sync;
	logic [31:0] pin_read;
	logic [31:0] prev_latch;
	logic [31:0][1:0] strong_cnt;
	logic [31:0][1:0] next_strong_cnt;
	iopm_lane_s [31:0] next_lane;
	iopm_dbg_e dbg_state;
	logic [9:0] dbg_ticks;
	logic dbg_hold;

	// ============================================================
	// Avalon-MM slave, one wait state on every access
	logic [3:0] kind;
	logic [1:0] port;
	logic addr_ok;
	logic wr_take;
	logic [7:0] wr_byte;
	logic [31:0] next_rdata;

	assign kind = AVS_ADDRESS_I[7:4];
	assign port = AVS_ADDRESS_I[3:2];
	assign addr_ok = (AVS_ADDRESS_I[1:0] == 2'b00);
	assign wr_take = AVS_WRITE_I & ~AVS_WAITREQUEST_O & addr_ok & AVS_BYTEENABLE_I[0];
	assign wr_byte = AVS_WRITEDATA_I[7:0] & port_mask[port];

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			AVS_WAITREQUEST_O <= 1'b1;
		else
			AVS_WAITREQUEST_O <= ~((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O);
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (addr_ok)
		begin
			case (kind)
				`IOPM_KIND_PORT: next_rdata = {24'h00_0000, pin_read[port*8 +: 8]};
				`IOPM_KIND_MODE_LOW: next_rdata = {24'h00_0000, mode_select_low[port]};
				`IOPM_KIND_MODE_HIGH: next_rdata = {24'h00_0000, mode_select_high[port]};
				`IOPM_KIND_INPUT_TYPE: next_rdata = {24'h00_0000, input_type_select[port]};
				`IOPM_KIND_SLEW: next_rdata = {24'h00_0000, slew_rate_select[port]};
				`IOPM_KIND_LATCH_READBACK: next_rdata = {24'h00_0000, latch[port]};
				`IOPM_KIND_CTRL:
				begin
					if (port == 2'd0)
					begin
						next_rdata[`IOPM_CTRL_PULLUP_BIT] = shared_pin_pullup_enable;
						next_rdata[`IOPM_CTRL_RPD_BIT] = RESET_PIN_DISABLE_CONFIG_I;
						next_rdata[`IOPM_CTRL_DBG_HOLD_BIT] = dbg_hold;
					end
				end
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data is sampled in the wait cycle and holds through the taking edge
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			AVS_READDATA_O <= 32'h0000_0000;
		else if (AVS_READ_I & AVS_WAITREQUEST_O)
			AVS_READDATA_O <= next_rdata;
	end

	// ============================================================
	// Software registers, one process per register
	// Unimplemented bits keep their reset value until the first write masks them
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			latch <= {4{`IOPM_RST_LATCH}};
		else if (wr_take && (kind == `IOPM_KIND_PORT || kind == `IOPM_KIND_LATCH_READBACK))
			latch[port] <= wr_byte;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			mode_select_low <= {4{`IOPM_RST_MODE_LOW}};
		else if (wr_take && kind == `IOPM_KIND_MODE_LOW)
			mode_select_low[port] <= wr_byte;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			mode_select_high <= {4{`IOPM_RST_MODE_HIGH}};
		else if (wr_take && kind == `IOPM_KIND_MODE_HIGH)
			mode_select_high[port] <= wr_byte;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			input_type_select <= {4{`IOPM_RST_INPUT_TYPE}};
		else if (wr_take && kind == `IOPM_KIND_INPUT_TYPE)
			input_type_select[port] <= wr_byte;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			slew_rate_select <= {4{`IOPM_RST_SLEW}};
		else if (wr_take && kind == `IOPM_KIND_SLEW)
			slew_rate_select[port] <= wr_byte;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			shared_pin_pullup_enable <= `IOPM_RST_PULLUP;
		else if (wr_take && kind == `IOPM_KIND_CTRL && port == 2'd0)
			shared_pin_pullup_enable <= AVS_WRITEDATA_I[`IOPM_CTRL_PULLUP_BIT];
	end

	// ============================================================
	// Debug pin hold after reset, counted in slow oscillator ticks
	assign dbg_hold = (dbg_state == DBG_HOLD);

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			dbg_state <= DBG_HOLD;
			dbg_ticks <= 10'h000;
		end
		else
		begin
			case (dbg_state)
				DBG_HOLD:
				begin
					if (LOW_SPEED_OSC_TICK_I)
					begin
						dbg_ticks <= dbg_ticks + 10'h001;
						if (dbg_ticks == `IOPM_DBG_HOLD_TICKS - 10'h001)
							dbg_state <= DBG_RELEASED;
					end
				end
				DBG_RELEASED: dbg_state <= DBG_RELEASED;
				default: dbg_state <= DBG_RELEASED;
			endcase
		end
	end

	// ============================================================
	// Pin input path
	// The weak pull-high trails the pin by three edges; an external sink must overpower it
	iopm_sync u_sync (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.async_i(PIN_I),
		.sync_o(pin_sync)
	);

	// Shared pin reads zero while it serves as the reset input
	always_comb
	begin
		pin_read = pin_sync & port_mask;
		if (RESET_PIN_DISABLE_CONFIG_I)
			pin_read[`IOPM_LANE_SHARED] = 1'b0;
	end

	// ============================================================
	// Per-pin drivers
	genvar g;
	generate
		for (g = 0; g < 32; g++)
		begin : g_lane
			localparam bit is_dbg = (g == `IOPM_LANE_DBG_DATA) || (g == `IOPM_LANE_DBG_CLK);
			localparam bit is_shared = (g == `IOPM_LANE_SHARED);
			logic lat;
			logic rise;
			iopm_mode_e mode;

			always_comb
			begin
				lat = latch[g / 8][g % 8];
				case ({mode_select_low[g / 8][g % 8], mode_select_high[g / 8][g % 8]})
					2'b00: mode = MODE_QUASI;
					2'b01: mode = MODE_PUSH_PULL;
					2'b10: mode = MODE_INPUT_ONLY;
					default: mode = MODE_OPEN_DRAIN;
				endcase
				if (is_dbg && dbg_hold)
				begin
					mode = MODE_QUASI;
					lat = 1'b1;
				end
				if (is_shared || !port_mask[g / 8][g % 8])
					mode = MODE_INPUT_ONLY;
				rise = lat & ~prev_latch[g];
				next_lane[g] = '0;
				next_strong_cnt[g] = 2'd0;
				case (mode)
					MODE_QUASI:
					begin
						if (rise)
							next_strong_cnt[g] = `IOPM_STRONG_CYCLES - 2'd1;
						else if (lat && strong_cnt[g] != 2'd0)
							next_strong_cnt[g] = strong_cnt[g] - 2'd1;
						next_lane[g].drive_en = ~lat | rise | (strong_cnt[g] != 2'd0);
						next_lane[g].drive_val = lat;
						next_lane[g].pull_vweak = lat;
						next_lane[g].pull_weak = pin_sync[g];
					end
					MODE_PUSH_PULL:
					begin
						next_lane[g].drive_en = 1'b1;
						next_lane[g].drive_val = lat;
					end
					MODE_OPEN_DRAIN:
					begin
						next_lane[g].drive_en = ~lat;
						next_lane[g].drive_val = 1'b0;
					end
					MODE_INPUT_ONLY: next_lane[g] = '0;
					default: next_lane[g] = '0;
				endcase
			end

			// Reset to the latch's reset level, so no strong pulse follows reset
			always_ff @(posedge CLK_I or negedge RST_N_I)
			begin
				if (!RST_N_I)
					prev_latch[g] <= 1'b1;
				else
					prev_latch[g] <= lat;
			end

			always_ff @(posedge CLK_I or negedge RST_N_I)
			begin
				if (!RST_N_I)
					strong_cnt[g] <= 2'd0;
				else
					strong_cnt[g] <= next_strong_cnt[g];
			end

			// Registered pad controls keep glitches off the pins
			always_ff @(posedge CLK_I or negedge RST_N_I)
			begin
				if (!RST_N_I)
				begin
					PIN_O[g] <= 1'b0;
					PIN_OE_N_O[g] <= 1'b1;
					PULL_WEAK_O[g] <= 1'b0;
					PULL_VWEAK_O[g] <= 1'b0;
				end
				else
				begin
					PIN_O[g] <= next_lane[g].drive_val;
					PIN_OE_N_O[g] <= ~next_lane[g].drive_en;
					PULL_WEAK_O[g] <= next_lane[g].pull_weak;
					PULL_VWEAK_O[g] <= next_lane[g].pull_vweak;
				end
			end

			// Input type and slew only shape the pad; they never gate the data path
			always_ff @(posedge CLK_I or negedge RST_N_I)
			begin
				if (!RST_N_I)
				begin
					SCHMITT_O[g] <= 1'b0;
					FAST_SLEW_O[g] <= 1'b0;
				end
				else
				begin
					if (is_shared)
						SCHMITT_O[g] <= 1'b1;
					else
						SCHMITT_O[g] <= input_type_select[g / 8][g % 8];
					FAST_SLEW_O[g] <= slew_rate_select[g / 8][g % 8];
				end
			end
		end
	endgenerate

	// ============================================================
	// Shared pin pull-up: forced on while the pin is the reset input
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			SHARED_PULLUP_O <= 1'b1;
		else
			SHARED_PULLUP_O <= RESET_PIN_DISABLE_CONFIG_I | shared_pin_pullup_enable;
	end
endmodule : iopm_top
`default_nettype wire

// *** shared/iopm_regs.svh ***
`ifndef IOPM_REGS_SVH
`define IOPM_REGS_SVH
// ============================================================
// Register map: addr[7:4] selects the register kind, addr[3:2] the port
`define IOPM_KIND_PORT 4'h0
`define IOPM_KIND_MODE_LOW 4'h1
`define IOPM_KIND_MODE_HIGH 4'h2
`define IOPM_KIND_INPUT_TYPE 4'h3
`define IOPM_KIND_SLEW 4'h4
`define IOPM_KIND_LATCH_READBACK 4'h5
`define IOPM_KIND_CTRL 4'h6
`define IOPM_OFS_CTRL 8'h60
// ============================================================
// Control register fields
`define IOPM_CTRL_PULLUP_BIT 0
`define IOPM_CTRL_RPD_BIT 1
`define IOPM_CTRL_DBG_HOLD_BIT 2
// ============================================================
// Reset values
`define IOPM_RST_LATCH 8'hff
`define IOPM_RST_MODE_LOW 8'hff
`define IOPM_RST_MODE_HIGH 8'h00
`define IOPM_RST_INPUT_TYPE 8'h00
`define IOPM_RST_SLEW 8'h00
`define IOPM_RST_PULLUP 1'b0
// ============================================================
// Implemented pins per port (26 in all)
`define IOPM_MASK_P0 8'hff
`define IOPM_MASK_P1 8'hff
`define IOPM_MASK_P2 8'h07
`define IOPM_MASK_P3 8'h7f
// ============================================================
// Special lanes (port * 8 + bit)
`define IOPM_LANE_SHARED 16
`define IOPM_LANE_DBG_DATA 14
`define IOPM_LANE_DBG_CLK 15
// ============================================================
// Timing counts
`define IOPM_DBG_HOLD_TICKS 10'd600
`define IOPM_STRONG_CYCLES 2'd2
`endif

// *** shared/iopm_pkg.sv ***
// ============================================================
// Types
`default_nettype none
package iopm_pkg;
	typedef enum logic [1:0] {MODE_QUASI, MODE_PUSH_PULL, MODE_INPUT_ONLY, MODE_OPEN_DRAIN} iopm_mode_e;
	typedef enum logic {DBG_HOLD, DBG_RELEASED} iopm_dbg_e;
	typedef struct packed {
		logic drive_en;
		logic drive_val;
		logic pull_weak;
		logic pull_vweak;
	} iopm_lane_s;
endpackage : iopm_pkg
`default_nettype wire

// *** logic/iopm_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Two-flop synchroniser bank for the pin inputs
module iopm_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [31:0] async_i,
	output logic [31:0] sync_o
);
	logic [31:0] meta;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta <= 32'h0000_0000;
			sync_o <= 32'h0000_0000;
		end
		else
		begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule : iopm_sync
`default_nettype wire

// *** tb/iopm_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
// ========
// Pad and bus checks
module iopm_chk (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic RESET_PIN_DISABLE_CONFIG_I,
	input wire logic [31:0] PIN_I,
	input wire logic [31:0] PIN_O,
	input wire logic [31:0] PIN_OE_N_O,
	input wire logic [31:0] PULL_WEAK_O,
	input wire logic [31:0] PULL_VWEAK_O,
	input wire logic SHARED_PULLUP_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	logic qhi;
	assign qhi = !PIN_OE_N_O[0] && PIN_O[0] && PULL_VWEAK_O[0];
	strong_pulse_a: assert property ($rose(qhi) |=> qhi ##1 !qhi)
		else $error("strong pull width");
	weak_follow_a: assert property ((PULL_WEAK_O & ~$past(PIN_I, 3)) == 32'h0)
		else $error("weak pull on low pin");
	shared_pad_a: assert property (PIN_OE_N_O[16] && !PULL_VWEAK_O[16])
		else $error("shared pin driven");
	shared_pullup_a: assert property ($past(RESET_PIN_DISABLE_CONFIG_I)
		&& $past(RST_N_I) |-> SHARED_PULLUP_O)
		else $error("reset pin pull-up off");
	reset_read_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
		&& AVS_ADDRESS_I == 8'h08 && $past(RESET_PIN_DISABLE_CONFIG_I)
		|-> !AVS_READDATA_O[0])
		else $error("reset pin read 1");
	wait_one_a: assert property ($fell(AVS_WAITREQUEST_O) |=> AVS_WAITREQUEST_O)
		else $error("wait low too long");
	answer_bound_a: assert property ($rose(AVS_READ_I || AVS_WRITE_I)
		|-> ##1 !AVS_WAITREQUEST_O)
		else $error("late answer");
	reset_mode_a: assert property (!$past(RST_N_I)
		|-> ##1 (PULL_VWEAK_O == 32'h0000c000 && &PIN_OE_N_O))
		else $error("pads after reset");
	cover property ($rose(qhi));
	cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
	cover property (!PULL_WEAK_O[0] && PULL_VWEAK_O[0]);
endmodule : iopm_chk
`default_nettype wire

// *** tb/iopm_pins.sv ***
`timescale 1ns/10ps
`default_nettype none
// ========
// Far-side pin drivers
module iopm_pins (
	input wire logic clk_i,
	input wire logic [31:0] drv_i,
	input wire logic [31:0] oe_n_i,
	input wire logic [31:0] pull_i,
	input wire logic [31:0] ext_en_i,
	input wire logic [31:0] ext_val_i,
	output logic [31:0] pin_o
);
	// A floating pad toggles so that no stale level reads as valid
	logic [31:0] flt = 32'h0;
	always @(posedge clk_i)
		flt <= ~flt;
	// External sinks overpower the weak pull-ups
	always_comb
		for (int i = 0; i < 32; i++)
			pin_o[i] = !oe_n_i[i] ? drv_i[i] : ext_en_i[i] ? ext_val_i[i] : pull_i[i] | flt[i];
endmodule : iopm_pins
`default_nettype wire

// *** tb/iopm_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "iopm_regs.svh"
// ========
// Bench
module iopm_tb_top
	import iopm_pkg::*;
;
	logic CLK_I = 1'b0, RST_N_I = 1'b0, AVS_READ_I = 1'b0, AVS_WRITE_I = 1'b0;
	logic RESET_PIN_DISABLE_CONFIG_I = 1'b1, LOW_SPEED_OSC_TICK_I = 1'b0;
	logic [3:0] AVS_BYTEENABLE_I = 4'h1;
	logic [7:0] AVS_ADDRESS_I = 8'h00, lat, eo;
	logic [31:0] AVS_WRITEDATA_I = 32'h0, ext_en = 32'h0, ext_val = 32'h0, q, es, ef;
	logic [31:0] AVS_READDATA_O, PIN_I, PIN_O, PIN_OE_N_O, PULL_WEAK_O, PULL_VWEAK_O;
	logic [31:0] SCHMITT_O, FAST_SLEW_O;
	logic AVS_WAITREQUEST_O, SHARED_PULLUP_O;
	logic [7:0] mk [4] = '{8'hff, 8'hff, 8'h07, 8'h7f};
	int mismatches = 0, n_tests = 0, seed = 44, n;
	// Reference output latch per port, kept from the write rules alone
	int mdl_lat [4] = '{default: `IOPM_RST_LATCH};
	always #12.5 CLK_I = ~CLK_I;
	iopm_top dut (.*);
	iopm_pins u_pins (.clk_i(CLK_I), .drv_i(PIN_O), .oe_n_i(PIN_OE_N_O),
		.pull_i(PULL_WEAK_O | PULL_VWEAK_O | {15'h0, SHARED_PULLUP_O, 16'h0}),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(PIN_I));
	task complete_run;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge CLK_I);
	endtask : cyc
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I <= w;
		AVS_READ_I <= !w;
		@(posedge CLK_I);
		while (AVS_WAITREQUEST_O !== 1'b0)
			@(posedge CLK_I);
		q = AVS_READDATA_O;
		if (w && AVS_BYTEENABLE_I[0] && a[1:0] == 2'b00
			&& (a[7:4] == `IOPM_KIND_PORT || a[7:4] == `IOPM_KIND_LATCH_READBACK))
			mdl_lat[a[3:2]] = d[7:0] & mk[a[3:2]];
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		@(posedge CLK_I);
	endtask : acc
	task rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(e, q);
	endtask : rd
	initial
	begin
		cyc(8);
		RST_N_I <= 1'b1;
		cyc(1);
		for (int p = 0; p < 4; p++)
		begin
			rd(8'h10 + 8'(p * 4), `IOPM_RST_MODE_LOW);
			rd(8'h20 + 8'(p * 4), `IOPM_RST_MODE_HIGH);
			rd(8'h50 + 8'(p * 4), mdl_lat[p]);
		end
		LOW_SPEED_OSC_TICK_I <= 1'b1;
		cyc(590);
		chk(3, PULL_VWEAK_O[15:14]);
		cyc(20);
		chk(0, PULL_VWEAK_O[15:14]);
		for (int m = 0; m < 4; m++)
		begin
			lat = 8'($random(seed));
			acc(1'b1, 8'h10, {24'h0, {8{m[1]}}});
			acc(1'b1, 8'h20, {24'h0, {8{m[0]}}});
			acc(1'b1, 8'h00, lat);
			cyc(6);
			eo = m == MODE_PUSH_PULL ? 8'h00 : m == MODE_INPUT_ONLY ? 8'hff : lat;
			chk(eo, PIN_OE_N_O[7:0]);
			chk(m == MODE_PUSH_PULL ? lat : 0, PIN_O[7:0] & ~PIN_OE_N_O[7:0]);
			chk(m == MODE_QUASI ? lat : 0, PULL_VWEAK_O[7:0]);
			chk(m == MODE_QUASI ? lat : 0, PULL_WEAK_O[7:0]);
		end
		acc(1'b1, 8'h10, 0);
		acc(1'b1, 8'h20, 0);
		acc(1'b1, 8'h00, 0);
		acc(1'b1, 8'h00, 1);
		n = 0;
		repeat (8)
		begin
			@(posedge CLK_I);
			n += (PIN_OE_N_O[0] === 1'b0 && PIN_O[0] === 1'b1);
		end
		chk(2, n);
		ext_en <= 32'hffff;
		ext_val <= {16'h0, 8'($random(seed)), 8'h0};
		cyc(6);
		chk(1, {PULL_WEAK_O[0], PULL_VWEAK_O[0]});
		rd(8'h00, 0);
		rd(8'h04, ext_val[15:8]);
		AVS_BYTEENABLE_I <= 4'h0;
		acc(1'b1, 8'h50, 0);
		AVS_BYTEENABLE_I <= 4'h1;
		rd(8'h50, mdl_lat[0]);
		es = 32'h10000;
		ef = 0;
		for (int p = 0; p < 4; p++)
		begin
			lat = 8'($random(seed));
			acc(1'b1, 8'h30 + 8'(p * 4), lat);
			acc(1'b1, 8'h40 + 8'(p * 4), ~lat);
			rd(8'h30 + 8'(p * 4), lat & mk[p]);
			rd(8'h40 + 8'(p * 4), ~lat & mk[p]);
			es |= 32'(lat & mk[p]) << (p * 8);
			ef |= 32'(~lat & mk[p]) << (p * 8);
		end
		cyc(2);
		chk(es, SCHMITT_O);
		chk(ef, FAST_SLEW_O);
		RESET_PIN_DISABLE_CONFIG_I <= 1'b0;
		ext_en <= 32'h70000;
		ext_val <= 32'h10000;
		acc(1'b1, 8'h60, 1);
		cyc(2);
		chk(1, SHARED_PULLUP_O);
		rd(`IOPM_OFS_CTRL, 32'h1 << `IOPM_CTRL_PULLUP_BIT);
		acc(1'b1, 8'h60, 0);
		cyc(2);
		chk(0, SHARED_PULLUP_O);
		rd(8'h08, 1);
		acc(1'b1, 8'h28, 32'hff);
		acc(1'b1, 8'h08, 0);
		cyc(2);
		chk(1, PIN_OE_N_O[16]);
		RESET_PIN_DISABLE_CONFIG_I <= 1'b1;
		cyc(3);
		rd(8'h08, 0);
		chk(1, SHARED_PULLUP_O);
		rd(8'h70, 0);
		complete_run;
	end
	initial
	begin
		cyc(20000);
		mismatches++;
		complete_run;
	end
endmodule : iopm_tb_top
bind iopm_top iopm_chk u_chk (.*);
`default_nettype wire
